// [src/tlto_config.sv]
// two-level turn-off setup register with turn-off sequencer
// Function
// - bits 15-13 pick plateau level 6-13 V
// - bits 12-10 pick plateau hold time
// - bits 9-8 pick discharge current
// - writing reserved bit 7 raises integrity fault
// - bit 6 high skips configuration check
// - bit 5 selects soft turn-off after plateau
`timescale 1ns/1ps
`include "tlto_consts.svh"

module tlto_config (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // fault pin and check result
    input  wire logic        fault_pin,
    input  wire logic        crc_err,
    // configuration fields
    output logic      [2:0]  plateau_level_sel,
    output logic      [2:0]  plateau_hold_sel,
    output logic      [1:0]  plateau_discharge_sel,
    output logic             cfg_check_off,
    output logic             soft_off_after_plateau,
    // sequence drive
    output logic             gate_discharge,
    output logic             plateau_hold,
    output logic             soft_turnoff,
    output logic             hard_turnoff,
    // fault and interrupt
    output logic             cfg_integrity_fault,
    output logic             irq
);

    // ==================================================
    // plateau hold cycles per code
    function automatic logic [7:0] hold_cyc(input logic [2:0] code);
        case (code)
            3'h0: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD0_NS));
            3'h1: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD1_NS));
            3'h2: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD2_NS));
            3'h3: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD3_NS));
            3'h4: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD4_NS));
            3'h5: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD5_NS));
            3'h6: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD6_NS));
            default: hold_cyc = 8'(`TLTO_NS2CYC(`TLTO_HOLD7_NS));
        endcase
    endfunction

    tlto_pkg::tlto_setup_t setup;
    tlto_pkg::tlto_setup_t next_setup;
    tlto_pkg::tlto_state_t state;
    tlto_pkg::tlto_state_t next_state;
    logic [2:0]  status;
    logic [2:0]  next_status;
    logic [2:0]  mask;
    logic [2:0]  next_mask;
    logic [2:0]  events;
    logic [15:0] next_rdata;
    logic        next_fault;
    logic        next_irq;
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        fault_lvl;
    logic        next_fault_lvl;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic        next_gd;
    logic        next_ph;
    logic        next_soft;
    logic        next_hard;
    logic        seq_done;

    assign plateau_level_sel      = setup.level;
    assign plateau_hold_sel       = setup.hold;
    assign plateau_discharge_sel  = setup.disch;
    assign cfg_check_off          = setup.check_off;
    assign soft_off_after_plateau = setup.soft_off;

    // ==================================================
    // fault pin synchroniser, level taken when stages agree
    always_comb begin
        next_fault_lvl = fault_lvl;
        if (sync2 == sync3) begin
            next_fault_lvl = sync3;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            sync3     <= 1'b0;
            fault_lvl <= 1'b0;
        end else begin
            sync1     <= fault_pin;
            sync2     <= sync1;
            sync3     <= sync2;
            fault_lvl <= next_fault_lvl;
        end
    end

    // ==================================================
    // register file, status events and read data
    assign seq_done = (state == tlto_pkg::TLTO_FINAL) && !fault_lvl;

    always_comb begin
        events = 3'h0;
        events[`TLTO_ST_RSVD] = wr && (addr == `TLTO_ADDR_SETUP)
                                && wdata[`TLTO_RSVD_BIT];
        events[`TLTO_ST_CRC]  = crc_err && !setup.check_off;
        events[`TLTO_ST_DONE] = seq_done;
        next_setup  = setup;
        next_status = status;
        next_mask   = mask;
        next_rdata  = 16'h0000;
        if (wr) begin
            case (addr)
                `TLTO_ADDR_SETUP: begin
                    next_setup           = wdata;
                    next_setup.rsvd      = 1'b0;
                    next_setup.low       = 5'h00;
                end
                `TLTO_ADDR_STATUS: next_status = status & ~wdata[2:0];
                `TLTO_ADDR_MASK:   next_mask   = wdata[2:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        next_status = next_status | events;
        if (rd) begin
            case (addr)
                `TLTO_ADDR_SETUP:  next_rdata = setup;
                `TLTO_ADDR_STATUS: next_rdata = {13'h0000, status};
                `TLTO_ADDR_MASK:   next_rdata = {13'h0000, mask};
                default:           next_rdata = 16'h0000;
            endcase
        end
        next_fault = next_status[`TLTO_ST_RSVD]
                     | next_status[`TLTO_ST_CRC];
        next_irq   = |(next_status & next_mask);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            setup               <= `TLTO_SETUP_RST;
            status              <= `TLTO_STATUS_RST;
            mask                <= `TLTO_MASK_RST;
            rdata               <= 16'h0000;
            cfg_integrity_fault <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            setup               <= next_setup;
            status              <= next_status;
            mask                <= next_mask;
            rdata               <= next_rdata;
            cfg_integrity_fault <= next_fault;
            irq                 <= next_irq;
        end
    end

    // ==================================================
    // turn-off sequence: discharge, plateau hold, final off
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            tlto_pkg::TLTO_IDLE: begin
                if (fault_lvl) begin
                    next_state = tlto_pkg::TLTO_DISCH;
                    next_cnt   = 8'(`TLTO_DISCH_CYC - 1);
                end
            end
            tlto_pkg::TLTO_DISCH: begin
                if (cnt == 8'h00) begin
                    next_state = tlto_pkg::TLTO_HOLD;
                    next_cnt   = hold_cyc(setup.hold) - 8'h01;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            tlto_pkg::TLTO_HOLD: begin
                if (cnt == 8'h00) begin
                    next_state = tlto_pkg::TLTO_FINAL;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            tlto_pkg::TLTO_FINAL: begin
                if (!fault_lvl) begin
                    next_state = tlto_pkg::TLTO_IDLE;
                end
            end
            default: next_state = tlto_pkg::TLTO_IDLE;
        endcase
        next_gd   = next_state == tlto_pkg::TLTO_DISCH;
        next_ph   = next_state == tlto_pkg::TLTO_HOLD;
        next_soft = (next_state == tlto_pkg::TLTO_FINAL)
                    && setup.soft_off;
        next_hard = (next_state == tlto_pkg::TLTO_FINAL)
                    && !setup.soft_off;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state          <= tlto_pkg::TLTO_IDLE;
            cnt            <= 8'h00;
            gate_discharge <= 1'b0;
            plateau_hold   <= 1'b0;
            soft_turnoff   <= 1'b0;
            hard_turnoff   <= 1'b0;
        end else begin
            state          <= next_state;
            cnt            <= next_cnt;
            gate_discharge <= next_gd;
            plateau_hold   <= next_ph;
            soft_turnoff   <= next_soft;
            hard_turnoff   <= next_hard;
        end
    end

    // ==================================================
    // helper: plateau length and expected length
    logic [7:0] hold_len;
    logic [7:0] hold_exp;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_len <= 8'h00;
            hold_exp <= 8'h00;
        end else begin
            if (plateau_hold) begin
                hold_len <= hold_len + 8'h01;
            end else begin
                hold_len <= 8'h00;
            end
            if (next_ph && !plateau_hold) begin
                hold_exp <= hold_cyc(setup.hold);
            end
        end
    end

    // ==================================================
    // checks
    a_level_write: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == `TLTO_ADDR_SETUP
        |=> plateau_level_sel == $past(wdata[15:13]))
        else $error("plateau level not taken from write");

    a_hold_length: assert property (@(posedge mclk) disable iff (rst)
        $fell(plateau_hold) |-> hold_len == hold_exp)
        else $error("plateau hold length wrong");

    a_discharge_start: assert property (@(posedge mclk) disable iff (rst)
        state == tlto_pkg::TLTO_IDLE && fault_lvl
        |=> gate_discharge && !plateau_hold)
        else $error("discharge did not start on fault");

    a_discharge_length: assert property (@(posedge mclk) disable iff (rst)
        $rose(gate_discharge)
        |-> ##9 gate_discharge ##1 (!gate_discharge && plateau_hold))
        else $error("discharge phase length wrong");

    a_rsvd_fault: assert property (@(posedge mclk) disable iff (rst)
        wr && addr == `TLTO_ADDR_SETUP && wdata[`TLTO_RSVD_BIT]
        |=> status[`TLTO_ST_RSVD] && cfg_integrity_fault
            && rdata[`TLTO_RSVD_BIT] == 1'b0)
        else $error("reserved write did not raise fault");

    a_crc_flag: assert property (@(posedge mclk) disable iff (rst)
        crc_err && !cfg_check_off |=> status[`TLTO_ST_CRC])
        else $error("check error not flagged");

    a_crc_skip: assert property (@(posedge mclk) disable iff (rst)
        cfg_check_off && !status[`TLTO_ST_CRC]
        |=> !status[`TLTO_ST_CRC])
        else $error("check error flagged while check is off");

    a_soft_choice: assert property (@(posedge mclk) disable iff (rst)
        $rose(soft_turnoff || hard_turnoff)
        |-> soft_turnoff == $past(soft_off_after_plateau)
            && hard_turnoff != soft_turnoff)
        else $error("final turn-off mode wrong");

    a_read_back: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == `TLTO_ADDR_SETUP
        |=> rdata[15:5] == {$past(plateau_level_sel),
                            $past(plateau_hold_sel),
                            $past(plateau_discharge_sel), 1'b0,
                            $past(cfg_check_off),
                            $past(soft_off_after_plateau)}
            && rdata[4:0] == 5'h00)
        else $error("setup read-back mismatch");

endmodule // tlto_config

// [src/tlto_consts.svh]
// constants for the two-level turn-off setup block
`ifndef TLTO_CONSTS_SVH
`define TLTO_CONSTS_SVH
// ==================================================
// clock and register offsets (word index)
`define TLTO_MCLK_MHZ     100
`define TLTO_ADDR_SETUP   4'h0
`define TLTO_ADDR_STATUS  4'h1
`define TLTO_ADDR_MASK    4'h2
// ==================================================
// field positions and reset values
`define TLTO_RSVD_BIT     7
`define TLTO_ST_RSVD      0
`define TLTO_ST_CRC       1
`define TLTO_ST_DONE      2
`define TLTO_SETUP_RST    16'h0020
`define TLTO_STATUS_RST   3'h0
`define TLTO_MASK_RST     3'h0
// ==================================================
// timing: plateau hold per code, discharge phase
`define TLTO_NS2CYC(ns)   (((ns) * `TLTO_MCLK_MHZ) / 1000)
`define TLTO_HOLD0_NS     150
`define TLTO_HOLD1_NS     300
`define TLTO_HOLD2_NS     450
`define TLTO_HOLD3_NS     600
`define TLTO_HOLD4_NS     1000
`define TLTO_HOLD5_NS     1500
`define TLTO_HOLD6_NS     2000
`define TLTO_HOLD7_NS     2500
`define TLTO_DISCH_NS     100
`define TLTO_DISCH_CYC    `TLTO_NS2CYC(`TLTO_DISCH_NS)
`endif

// [src/tlto_pkg.sv]
// types for the two-level turn-off setup block
package tlto_pkg;
    // ==================================================
    // setup register layout
    typedef struct packed {
        logic [2:0] level;
        logic [2:0] hold;
        logic [1:0] disch;
        logic       rsvd;
        logic       check_off;
        logic       soft_off;
        logic [4:0] low;
    } tlto_setup_t;

    // ==================================================
    // turn-off sequence states, gray along the path
    typedef enum logic [1:0] {
        TLTO_IDLE  = 2'b00,
        TLTO_DISCH = 2'b01,
        TLTO_HOLD  = 2'b11,
        TLTO_FINAL = 2'b10
    } tlto_state_t;
endpackage

// [dv/test_two_level_turnoff_config.sv]
// self-checking bench for the two-level turn-off setup block
`timescale 1ns/1ps
`include "tlto_consts.svh"

module test_two_level_turnoff_config;
    // ==================================================
    // signals
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        fault_pin = 1'b0;
    logic        crc_err = 1'b0;
    logic [2:0]  lvl;
    logic [2:0]  hld;
    logic [1:0]  dis;
    logic        chk_off;
    logic        soft_en;
    logic        g_dis;
    logic        p_hold;
    logic        s_off;
    logic        h_off;
    logic        c_fault;
    logic        irq;
    logic        rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    int          num_errors = 0;
    int          tests_run = 0;
    int          hold_tab[8] = '{15, 30, 45, 60, 100, 150, 200, 250};

    tlto_config u_tlto_config (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fault_pin(fault_pin), .crc_err(crc_err),
        .plateau_level_sel(lvl), .plateau_hold_sel(hld),
        .plateau_discharge_sel(dis), .cfg_check_off(chk_off),
        .soft_off_after_plateau(soft_en), .gate_discharge(g_dis),
        .plateau_hold(p_hold), .soft_turnoff(s_off), .hard_turnoff(h_off),
        .cfg_integrity_fault(c_fault), .irq(irq)
    );

    // ==================================================
    // clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // ==================================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0 && exp_q.size() == 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one bus cycle; strobes driven for one edge and left set until the next call
    task automatic bus(input logic w, input logic r, input logic [3:0] a,
                       input logic [15:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
    endtask

    // read with the expected word noted for the monitor
    task automatic rdx(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? g_dis : (s == 1) ? p_hold : (s_off | h_off);
    endfunction

    // count edges while a sequence output keeps a level, bounded
    task automatic span(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) === v) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 400) begin
                num_errors++;
                end_sim();
            end
        end
    endtask

    // ==================================================
    // read monitor: oldest note compared when data appear
    always @(posedge mclk) begin
        rd_seen <= rd;
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("BAD rdata exp none got %h", rdata);
            end else begin
                chk("rdata", exp_q.pop_front(), rdata);
            end
        end
    end

    // ==================================================
    // main sequence
    initial begin
        logic [15:0] d;
        int          n;
        void'($urandom(32'hFF37));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("soft_en rst", 16'h0001, {15'h0, soft_en});
        rdx(`TLTO_ADDR_SETUP, 16'h0020);
        // every level code with random other fields, bit 7 clear
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], 13'($urandom())} & 16'hFF7F;
            bus(1'b1, 1'b0, `TLTO_ADDR_SETUP, d);
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            #1;
            chk("lvl", {13'h0, d[15:13]}, {13'h0, lvl});
            chk("hld", {13'h0, d[12:10]}, {13'h0, hld});
            chk("dis", {14'h0, d[9:8]}, {14'h0, dis});
            chk("chk_off", {15'h0, d[6]}, {15'h0, chk_off});
            chk("soft_en", {15'h0, d[5]}, {15'h0, soft_en});
            chk("fault", 16'h0000, {15'h0, c_fault});
            rdx(`TLTO_ADDR_SETUP, d & 16'hFF60);
        end
        // reserved bit written: integrity fault, interrupt, clear
        bus(1'b1, 1'b0, `TLTO_ADDR_MASK, 16'h0007);
        bus(1'b1, 1'b0, `TLTO_ADDR_SETUP, 16'h0080);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
        chk("fault rsvd", 16'h0001, {15'h0, c_fault});
        chk("irq rsvd", 16'h0001, {15'h0, irq});
        rdx(`TLTO_ADDR_STATUS, 16'h0001);
        rdx(`TLTO_ADDR_SETUP, 16'h0000);
        bus(1'b1, 1'b0, `TLTO_ADDR_STATUS, 16'h0001);
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        #1;
        chk("fault clr", 16'h0000, {15'h0, c_fault});
        chk("irq clr", 16'h0000, {15'h0, irq});
        rdx(`TLTO_ADDR_MASK, 16'h0007);
        // check error ignored when skipped, seen when enabled
        for (int k = 1; k >= 0; k--) begin
            bus(1'b1, 1'b0, `TLTO_ADDR_SETUP, k ? 16'h0040 : 16'h0000);
            crc_err <= 1'b1;
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            crc_err <= 1'b0;
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            #1;
            chk("fault crc", k ? 16'h0000 : 16'h0001, {15'h0, c_fault});
            rdx(`TLTO_ADDR_STATUS, k ? 16'h0000 : 16'h0002);
        end
        bus(1'b1, 1'b0, `TLTO_ADDR_STATUS, 16'h0002);
        // unmapped place: write ignored, read zero
        bus(1'b1, 1'b0, 4'hF, 16'hFFFF);
        rdx(4'hF, 16'h0000);
        rdx(`TLTO_ADDR_SETUP, 16'h0000);
        // turn-off sequence: shortest hold with soft, longest with hard
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 1'b0, `TLTO_ADDR_SETUP, k ? 16'hFF00 : 16'h0020);
            bus(1'b0, 1'b0, 4'h0, 16'h0000);
            fault_pin <= 1'b1;
            #1;
            span(0, 1'b0, n);
            span(0, 1'b1, n);
            chk("disch len", 16'(`TLTO_DISCH_CYC), 16'(n));
            span(1, 1'b1, n);
            chk("hold len", 16'(hold_tab[k ? 7 : 0]), 16'(n));
            chk("soft", k ? 16'h0000 : 16'h0001, {15'h0, s_off});
            chk("hard", k ? 16'h0001 : 16'h0000, {15'h0, h_off});
            fault_pin <= 1'b0;
            span(2, 1'b1, n);
            rdx(`TLTO_ADDR_STATUS, 16'h0004);
            bus(1'b1, 1'b0, `TLTO_ADDR_STATUS, 16'h0004);
        end
        bus(1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (3) @(posedge mclk);
        end_sim();
    end
endmodule // test_two_level_turnoff_config
